// ==== adc_sel_pkg.sv ====
// Purpose: constants for the converter reference and input selection block
// Assumes: APB slave, 32-bit data, one word per register
// Notes: register byte addresses are the printed offsets times four
package adc_sel_pkg;
  localparam int unsigned IDX_CTRL_B = 32'h0000007B;
  localparam int unsigned IDX_INSEL = 32'h0000007C;
  localparam logic [11:0] ADDR_CTRL_B = 12'h1EC;
  localparam logic [11:0] ADDR_INSEL = 12'h1F0;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h200;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h204;
  localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h208;
  localparam logic [11:0] ADDR_RESULT = 12'h20C;
  localparam logic [11:0] ADDR_ACTIVE = 12'h210;
  localparam logic [7:0] RESET_CTRL_B = 8'h00;
  localparam logic [7:0] RESET_INSEL = 8'h00;
  localparam logic [7:0] CTRL_B_WMASK = 8'h4F;
  localparam int REF_MSB = 7;
  localparam int REF_LSB = 6;
  localparam int ALIGN_BIT = 5;
  localparam int CHAN_LOW_MSB = 4;
  localparam int CHAN_HIGH_BIT = 3;
  localparam int TRIG_MSB = 2;
  localparam int CMUX_BIT = 6;
  localparam logic [1:0] REF_PIN = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_INT_1V1 = 2'h2;
  localparam logic [1:0] REF_INT_2V56 = 2'h3;
  localparam logic [1:0] GAIN_1X = 2'h0;
  localparam logic [1:0] GAIN_10X = 2'h1;
  localparam logic [1:0] GAIN_200X = 2'h2;
  localparam logic [1:0] IRQ_DONE = 2'h0;
  localparam logic [1:0] IRQ_CFG = 2'h1;
  typedef enum logic [1:0] {IDLE, CONVERT} conv_state_t;
endpackage : adc_sel_pkg

// ==== adc_chan_decode.sv ====
// Purpose: decode a six-bit selector into input routing and gain
// Assumes: selector already latched for the running conversion
// Notes: codes above the table give an invalid flag; output registered
`timescale 1ns/10ps
module adc_chan_decode (
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] code,
  output logic [3:0] pos_input,
  output logic [3:0] neg_input,
  output logic differential,
  output logic [1:0] gain,
  output logic code_valid
);
  wire logic single_w = (code[5:3] == 3'h0);
  wire logic gained_w = (code[5:3] == 3'h1);
  wire logic unity_w = (code[5:4] == 2'h1) && (code <= 6'h19);
  // gained pairs: bit2 picks pair 0/1 or 2/3, bit1 picks 10x or 200x
  wire logic [3:0] g_neg_w = code[2] ? 4'h2 : 4'h0;
  wire logic [3:0] g_pos_w = g_neg_w + {3'h0, code[0]};
  wire logic [3:0] u_pos_w = code[3] ? {3'h0, code[0]} : {1'h0, code[2:0]};
  wire logic [3:0] u_neg_w = code[3] ? 4'h2 : 4'h1;
  always_ff @(posedge clk) begin
    if (srst) begin
      pos_input <= 4'h0;
      neg_input <= 4'h0;
      differential <= 1'b0;
      gain <= adc_sel_pkg::GAIN_1X;
      code_valid <= 1'b1;
    end else begin
      pos_input <= single_w ? {1'h0, code[2:0]} :
                   (gained_w ? g_pos_w : (unity_w ? u_pos_w : 4'h0)); // [RULE12] [RULE13]
      neg_input <= gained_w ? g_neg_w : (unity_w ? u_neg_w : 4'h0); // [RULE13]
      differential <= gained_w || unity_w;
      gain <= gained_w ? (code[1] ? adc_sel_pkg::GAIN_200X : adc_sel_pkg::GAIN_10X)
                       : adc_sel_pkg::GAIN_1X;
      code_valid <= single_w || gained_w || unity_w;
    end
  end
  a_single_route: assert property (@(posedge clk) disable iff (srst)
    (code[5:3] == 3'h0) |=> (!differential && gain == 2'h0 && pos_input == {1'h0, $past(code[2:0])}))
    else $error("single-ended code decoded wrongly"); // [RULE12]
  a_gain_pair: assert property (@(posedge clk) disable iff (srst)
    (code == 6'h0F) |=> (differential && gain == 2'h2 && pos_input == 4'h3 && neg_input == 4'h2))
    else $error("gained pair decoded wrongly"); // [RULE13]
  a_unity_neg: assert property (@(posedge clk) disable iff (srst)
    (code == 6'h19) |=> (differential && gain == 2'h0 && pos_input == 4'h1 && neg_input == 4'h2))
    else $error("unity pair decoded wrongly"); // [RULE13]
endmodule : adc_chan_decode

// ==== adc_input_reference_select.sv ====
// Purpose: reference, alignment and channel selection registers for the converter
// Assumes: converter core signals conv_start and conv_done on clk
// Notes: reference and channel latch at conversion start, alignment is live
//
// Notes on behaviour
// [RULE1] reference field bits 7:6 pick pin, supply, 1.1V or 2.56V
// [RULE2] reference change mid-conversion waits for conversion completion
// [RULE3] software avoids internal references while the reference pin is driven
// [RULE4] with 10x or 200x gain software uses only the 2.56V internal reference
// [RULE5] software never uses 1.1V internal reference for differential conversion
// [RULE6] bit 5 set gives left aligned result, clear gives right aligned
// [RULE7] alignment change alters the held result presentation at once
// [RULE8] bits 4:0 choose inputs and gain; change waits for completion
// [RULE9] bit 3 of control register b is the sixth selector bit
// [RULE10] sixth selector bit change waits for the running conversion to finish
// [RULE11] on reduced-pin variants the sixth selector bit does nothing
// [RULE12] codes 0 to 7 are single-ended inputs 0 to 7, no gain
// [RULE13] codes 8-15 gained pairs, 16-25 unity pairs with negative input 1 or 2
// [RULE14] result loads into the data pair when completion flag sets
// [RULE15] single-ended results are unsigned 0x000 to 0x3FF
// [RULE16] differential results are two's complement 0x200 to 0x1FF
// [RULE17] left: high byte bits 9:2, low byte top bits 1:0; right: low 7:0
// [RULE18] control register b bits 7, 5 and 4 read zero, ignore writes
`timescale 1ns/10ps
module adc_input_reference_select #(
  parameter bit WIDE_PINOUT = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [9:0] conv_result,
  output logic [1:0] reference_select,
  output logic [3:0] pos_input,
  output logic [3:0] neg_input,
  output logic differential,
  output logic [1:0] gain,
  output logic code_valid,
  output logic conversion_done_flag,
  output logic [7:0] result_low_byte,
  output logic [7:0] result_high_byte,
  output logic [2:0] trigger_source_select,
  output logic comparator_mux_enable,
  output logic irq
);
  // ==========================================================
  // register bus decode
  logic [7:0] insel_r;
  logic [7:0] ctrl_b_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_enable_r;
  logic [9:0] result_r;
  logic [1:0] active_ref_r;
  logic [5:0] active_code_r;
  logic busy_r;
  logic flag_r;
  adc_sel_pkg::conv_state_t state_r;

  wire logic access_w = psel && penable;
  wire logic wr_w = access_w && pwrite;
  wire logic hit_insel_w = (paddr == adc_sel_pkg::ADDR_INSEL);
  wire logic hit_ctrl_b_w = (paddr == adc_sel_pkg::ADDR_CTRL_B);
  wire logic hit_stat_w = (paddr == adc_sel_pkg::ADDR_IRQ_STATUS);
  wire logic hit_en_w = (paddr == adc_sel_pkg::ADDR_IRQ_ENABLE);
  wire logic hit_clr_w = (paddr == adc_sel_pkg::ADDR_IRQ_CLEAR);
  wire logic hit_res_w = (paddr == adc_sel_pkg::ADDR_RESULT);
  wire logic hit_act_w = (paddr == adc_sel_pkg::ADDR_ACTIVE);
  wire logic mapped_w = hit_insel_w || hit_ctrl_b_w || hit_stat_w || hit_en_w
                        || hit_clr_w || hit_res_w || hit_act_w;
  wire logic wr_insel_w = wr_w && hit_insel_w;
  wire logic wr_ctrl_b_w = wr_w && hit_ctrl_b_w;

  assign pready = 1'b1;
  assign pslverr = access_w && !mapped_w;

  // ==========================================================
  // control registers
  wire logic [7:0] ctrl_b_nxt = pwdata[7:0] & adc_sel_pkg::CTRL_B_WMASK; // [RULE18]
  always_ff @(posedge clk) begin
    if (srst) begin
      insel_r <= adc_sel_pkg::RESET_INSEL;
      ctrl_b_r <= adc_sel_pkg::RESET_CTRL_B;
    end else begin
      if (wr_insel_w) insel_r <= pwdata[7:0];
      if (wr_ctrl_b_w) ctrl_b_r <= ctrl_b_nxt;
    end
  end

  wire logic align_left_w = insel_r[adc_sel_pkg::ALIGN_BIT];
  wire logic high_sel_w = WIDE_PINOUT ? ctrl_b_r[adc_sel_pkg::CHAN_HIGH_BIT] : 1'b0; // [RULE11]
  wire logic [5:0] code_w = {high_sel_w, insel_r[adc_sel_pkg::CHAN_LOW_MSB:0]}; // [RULE9]
  wire logic [1:0] ref_w = insel_r[adc_sel_pkg::REF_MSB:adc_sel_pkg::REF_LSB]; // [RULE1]

  // ==========================================================
  // conversion tracking: reference and selector are frozen while a conversion runs
  wire logic start_w = conv_start && (state_r == adc_sel_pkg::IDLE);
  wire logic done_w = conv_done && (state_r == adc_sel_pkg::CONVERT);
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= adc_sel_pkg::IDLE;
    end else begin
      unique case (state_r)
        adc_sel_pkg::IDLE: if (start_w) state_r <= adc_sel_pkg::CONVERT;
        adc_sel_pkg::CONVERT: if (done_w) state_r <= adc_sel_pkg::IDLE;
      endcase
    end
  end
  assign busy_r = (state_r == adc_sel_pkg::CONVERT);

  always_ff @(posedge clk) begin
    if (srst) begin
      active_ref_r <= adc_sel_pkg::REF_PIN;
      active_code_r <= 6'h00;
    end else if (!busy_r || done_w) begin
      active_ref_r <= ref_w; // [RULE2]
      active_code_r <= code_w; // [RULE8] [RULE10]
    end
  end
  assign reference_select = active_ref_r;

  adc_chan_decode u_decode (
    .clk(clk),
    .srst(srst),
    .code(active_code_r),
    .pos_input(pos_input),
    .neg_input(neg_input),
    .differential(differential),
    .gain(gain),
    .code_valid(code_valid)
  );

  // ==========================================================
  // result capture and presentation
  always_ff @(posedge clk) begin
    if (srst) begin
      result_r <= 10'h000;
      flag_r <= 1'b0;
    end else begin
      if (done_w) result_r <= conv_result; // [RULE14] [RULE15] [RULE16]
      if (done_w) flag_r <= 1'b1; // [RULE14]
      else if (wr_w && hit_clr_w && pwdata[adc_sel_pkg::IRQ_DONE]) flag_r <= 1'b0;
    end
  end
  assign conversion_done_flag = flag_r;

  // alignment is combinational on the held word, so it changes at once
  wire logic [7:0] low_w = align_left_w ? {result_r[1:0], 6'h00} : result_r[7:0]; // [RULE6] [RULE17]
  wire logic [7:0] high_w = align_left_w ? result_r[9:2] : {6'h00, result_r[9:8]}; // [RULE7] [RULE17]
  assign result_low_byte = low_w;
  assign result_high_byte = high_w;
  assign trigger_source_select = ctrl_b_r[adc_sel_pkg::TRIG_MSB:0];
  assign comparator_mux_enable = ctrl_b_r[adc_sel_pkg::CMUX_BIT];

  // ==========================================================
  // interrupts: done event and an event for an input select write during a conversion
  wire logic cfg_evt_w = wr_insel_w && busy_r;
  wire logic [1:0] evt_w = {cfg_evt_w, done_w};
  wire logic [1:0] clr_w = (wr_w && hit_clr_w) ? pwdata[1:0] : 2'h0;
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_status_r <= 2'h0;
      irq_enable_r <= 2'h0;
    end else begin
      irq_status_r <= (irq_status_r & ~clr_w) | evt_w;
      if (wr_w && hit_en_w) irq_enable_r <= pwdata[1:0];
    end
  end
  assign irq = |(irq_status_r & irq_enable_r);

  // ==========================================================
  // read data
  wire logic [31:0] rd_w =
    hit_insel_w ? {24'h0, insel_r} :
    hit_ctrl_b_w ? {24'h0, ctrl_b_r} : // [RULE18]
    hit_stat_w ? {30'h0, irq_status_r} :
    hit_en_w ? {30'h0, irq_enable_r} :
    hit_res_w ? {16'h0, high_w, low_w} :
    hit_act_w ? {23'h0, busy_r, active_ref_r, active_code_r} : 32'h0;
  always_ff @(posedge clk) begin
    if (srst) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) prdata <= rd_w;
  end

  // ==========================================================
  // checks
  a_ref_hold: assert property (@(posedge clk) disable iff (srst)
    (busy_r && !conv_done) |=> $stable(active_ref_r))
    else $error("reference changed during conversion"); // [RULE2]
  a_code_hold: assert property (@(posedge clk) disable iff (srst)
    (busy_r && !conv_done) |=> $stable(active_code_r))
    else $error("selector changed during conversion"); // [RULE8]
  a_ref_decode: assert property (@(posedge clk) disable iff (srst)
    (!busy_r) |=> (reference_select == $past(insel_r[7:6])))
    else $error("reference does not follow the field when idle"); // [RULE1]
  a_align_left: assert property (@(posedge clk) disable iff (srst)
    align_left_w |-> (result_high_byte == result_r[9:2] && result_low_byte[5:0] == 6'h00))
    else $error("left alignment wrong"); // [RULE6]
  a_align_now: assert property (@(posedge clk) disable iff (srst)
    (!align_left_w) |-> (result_low_byte == result_r[7:0] && result_high_byte[7:2] == 6'h00))
    else $error("right alignment wrong"); // [RULE7]
  a_result_load: assert property (@(posedge clk) disable iff (srst)
    done_w |=> (conversion_done_flag && result_r == $past(conv_result)))
    else $error("result not loaded with flag"); // [RULE14]
  a_high_bit_gate: assert property (@(posedge clk) disable iff (srst)
    (!WIDE_PINOUT) |-> !code_w[5])
    else $error("sixth selector bit active on reduced part"); // [RULE11]
  a_ctrl_b_res: assert property (@(posedge clk) disable iff (srst)
    (ctrl_b_r & 8'hB0) == 8'h00)
    else $error("reserved bits set"); // [RULE18]
  a_high_joins: assert property (@(posedge clk) disable iff (srst)
    (!busy_r && WIDE_PINOUT) |=> (active_code_r[5] == $past(ctrl_b_r[3])))
    else $error("sixth bit not joined"); // [RULE9] [RULE10]
endmodule : adc_input_reference_select

// ==== conv_core_model.sv ====
// Purpose: behavioural converter core producing start, done and result
// Assumes: go is a one-cycle request from the bench
// Notes: result line carries a toggling pattern outside the done pulse
`timescale 1ns/10ps
module conv_core_model #(
  parameter int CONV_CYCLES = 20
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic go,
  input wire logic [9:0] value,
  output logic conv_start,
  output logic conv_done,
  output logic [9:0] conv_result
);
  int count_r;
  logic [9:0] junk_r;
  always_ff @(posedge clk) begin
    conv_start <= 1'b0;
    conv_done <= 1'b0;
    junk_r <= ~junk_r;
    conv_result <= junk_r;
    if (srst) begin
      count_r <= 0;
      junk_r <= 10'h155;
    end else if (go && count_r == 0) begin
      conv_start <= 1'b1;
      count_r <= CONV_CYCLES;
    end else if (count_r == 1) begin
      conv_done <= 1'b1;
      conv_result <= value;
      count_r <= 0;
    end else if (count_r > 1) begin
      count_r <= count_r - 1;
    end
  end
endmodule : conv_core_model

// ==== tb.sv ====
// Purpose: self-checking bench for reference, alignment and channel selection
// Assumes: zero-wait APB slave, core model with a fixed conversion length
// Notes: expectations come from the selector table and field layout
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, go = 1'b0, conv_start, conv_done, differential, code_valid;
  logic [9:0] conv_result, value = 10'h000;
  logic [1:0] reference_select, gain;
  logic [3:0] pos_input, neg_input;
  logic conversion_done_flag, comparator_mux_enable, irq;
  logic [7:0] result_low_byte, result_high_byte;
  logic [2:0] trigger_source_select;
  logic [5:0] codes [8] = '{6'h07, 6'h0D, 6'h0E, 6'h09, 6'h17, 6'h19, 6'h1A, 6'h20};
  logic [11:0] routes [8] = '{12'h807, 12'hD23, 12'hE22, 12'hD01, 12'hC17, 12'hC21, 12'h000,
    12'h000};
  int err_total = 0, check_count = 0, i;
  adc_input_reference_select dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_start(conv_start), .conv_done(conv_done),
    .conv_result(conv_result), .reference_select(reference_select), .pos_input(pos_input),
    .neg_input(neg_input), .differential(differential), .gain(gain), .code_valid(code_valid),
    .conversion_done_flag(conversion_done_flag), .result_low_byte(result_low_byte),
    .result_high_byte(result_high_byte), .trigger_source_select(trigger_source_select),
    .comparator_mux_enable(comparator_mux_enable), .irq(irq));
  conv_core_model core (.clk(clk), .srst(srst), .go(go), .value(value),
    .conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result));
  // ==========================================
  // clock, checks and bus tasks
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic set_code(input logic [5:0] c, input logic [2:0] top);
    apb(1'b1, adc_sel_pkg::ADDR_CTRL_B, {28'h0, c[5], 3'h0});
    apb(1'b1, adc_sel_pkg::ADDR_INSEL, {24'h0, top, c[4:0]});
    idle(3);
  endtask : set_code
  // ==========================================
  // test sequence
  initial begin
    #200000 err_total++;
    wrap_up();
  end
  initial begin
    idle(8);
    srst <= 1'b0;
    apb(1'b0, adc_sel_pkg::ADDR_INSEL, 32'h0);
    chk("insel reset", rd, 32'h0);
    apb(1'b0, adc_sel_pkg::ADDR_CTRL_B, 32'h0);
    chk("ctrl_b reset", rd, 32'h0);
    apb(1'b1, adc_sel_pkg::ADDR_CTRL_B, 32'hFF);
    apb(1'b0, adc_sel_pkg::ADDR_CTRL_B, 32'h0);
    chk("ctrl_b mask", rd, 32'h4F);
    chk("trigger", trigger_source_select, 3'h7);
    chk("cmux", comparator_mux_enable, 1'b1);
    for (i = 0; i < 4; i++) begin
      set_code(6'h00, {i[1:0], 1'b0});
      chk("reference", reference_select, i[1:0]);
    end
    for (i = 0; i < 8; i++) begin
      set_code(codes[i], 3'h6);
      chk("routing", {code_valid, differential, gain, differential ? neg_input : 4'h0,
        pos_input}, routes[i]);
    end
    set_code(6'h0D, 3'h7);
    value <= 10'h270;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    idle(2);
    apb(1'b1, adc_sel_pkg::ADDR_INSEL, 32'h60);
    apb(1'b1, adc_sel_pkg::ADDR_CTRL_B, 32'h08);
    chk("frozen ref", reference_select, 2'h3);
    chk("frozen route", {gain, pos_input, neg_input}, 10'h132);
    for (i = 0; i < 100 && conversion_done_flag !== 1'b1; i++) @(posedge clk);
    idle(3);
    chk("new ref", reference_select, 2'h1);
    chk("new code valid", code_valid, 1'b0);
    chk("left bytes", {result_high_byte, result_low_byte}, 16'h9C00);
    apb(1'b1, adc_sel_pkg::ADDR_INSEL, 32'h40);
    idle(1);
    chk("right bytes", {result_high_byte, result_low_byte}, 16'h0270);
    apb(1'b0, adc_sel_pkg::ADDR_RESULT, 32'h0);
    chk("result word", rd, 32'h270);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, adc_sel_pkg::ADDR_IRQ_ENABLE, 32'h1);
    idle(1);
    chk("irq on", irq, 1'b1);
    apb(1'b1, adc_sel_pkg::ADDR_IRQ_CLEAR, 32'h3);
    idle(1);
    chk("flag clear", {conversion_done_flag, irq}, 2'h0);
    apb(1'b0, 12'h3FC, 32'h0);
    chk("unmapped error", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    wrap_up();
  end
endmodule : tb
